// >>> pkg/rscl_defs.vh
// Strap field positions, reset defaults and selection codes for the strap latch
`ifndef RSCL_DEFS_VH
`define RSCL_DEFS_VH

// Host data pin positions carrying straps
`define RSCL_HD_WIDTH        16
`define RSCL_HD_BOOT_LO      3
`define RSCL_HD_BOOT_HI      4
`define RSCL_HD_ENDIAN       8
`define RSCL_HD_LANE_FIX     12
`define RSCL_HD_HOST_EN      14

// Values held while reset is asserted (documented defaults)
`define RSCL_RST_LANE_FIX    1'b1
`define RSCL_RST_LITTLE      1'b1
`define RSCL_RST_BOOT        2'h1
`define RSCL_RST_CLK_SRC     1'b1
`define RSCL_RST_HOST_EN     1'b1
`define RSCL_RST_LANE        1'b0
`define RSCL_RST_BOOT_HOST   1'b0
`define RSCL_RST_BOOT_ROM    1'b1
`define RSCL_RST_ROM_WIDTH   2'h1
`define RSCL_RST_CLK_RES     1'b0
`define RSCL_RST_AUDIO       1'b0
`define RSCL_RST_GP          16'h0000
`define RSCL_RST_VALID       1'b0

// Boot select codes
`define RSCL_BOOT_HOST       2'h0
`define RSCL_BOOT_ROM8       2'h1
`define RSCL_BOOT_ROM16      2'h2
`define RSCL_BOOT_ROM32      2'h3

// ROM width codes: 0 none, 1 8-bit, 2 16-bit, 3 32-bit
`define RSCL_ROMW_NONE       2'h0
`define RSCL_ROMW_8          2'h1
`define RSCL_ROMW_16         2'h2
`define RSCL_ROMW_32         2'h3

// Byte lane codes for narrow memory data
`define RSCL_LANE_LOW        1'b0
`define RSCL_LANE_HIGH       1'b1

// Shared general-purpose pins released when the host port is off (15:8, 3, 1, 0)
`define RSCL_GP_WIDTH        16
`define RSCL_GP_SHARED_MASK  16'hff0b

`endif

// >>> logic/rscl_capture.v
// Release-edge capture register for a group of strap bits
`timescale 1ns/100ps
`include "rscl_defs.vh"

module rscl_capture #(
    parameter                  WIDTH    = 6,
    parameter [WIDTH-1:0]      RST_VAL  = {WIDTH{1'b0}}
) (
    // Clock and reset
    input  wire                clk_i,
    input  wire                rst_b_i,
    // Strap levels
    input  wire [WIDTH-1:0]    strap_i,
    // Captured values
    output reg  [WIDTH-1:0]    held_o,
    output reg                 done_o
);

    // Reset loads constants only; pins are sampled on the first clocked edge after release
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            held_o <= RST_VAL;
            done_o <= 1'b0;
        end else if (!done_o) begin
            held_o <= strap_i;
            done_o <= 1'b1;
        end
    end

endmodule

// >>> logic/rscl_strap_latch.v
// Configuration strap latch: captures straps at reset release and decodes them
`timescale 1ns/100ps
`include "rscl_defs.vh"

// What this block does
// - Lane fix low: narrow data on low lane
// - Lane fix high, little endian: low lane
// - Lane fix high, big endian: high lane
// - Endian strap 0 big, 1 little
// - Boot code 00: host port boot
// - Codes 01/10/11: ROM boot 8/16/32 bits
// - Clock strap 1 selects square wave input
// - Host enable strap latched, selects pin owner
// - Host enable 0: audio port and GP pins
// - Host enable 1: host port owns pins
// - No software path changes pin selection
module rscl_strap_latch (
    // Clock and reset
    input  wire                        clk_i,
    input  wire                        rst_b_i,
    // Strap pins
    input  wire [`RSCL_HD_WIDTH-1:0]   host_data_pins_i,
    input  wire                        clock_source_strap_i,
    // Memory lane steering
    output reg                         little_endian_flag_o,
    output reg                         big_endian_lane_fix_o,
    output reg                         narrow_data_lane_o,
    // Boot selection
    output reg  [1:0]                  boot_select_o,
    output reg                         boot_host_port_o,
    output reg                         boot_rom_o,
    output reg  [1:0]                  boot_rom_width_o,
    // Clock source
    output reg                         clk_src_square_wave_o,
    output reg                         clk_src_reserved_o,
    // Shared pin ownership
    output reg                         host_port_enable_o,
    output reg                         audio_serial_port_one_enable_o,
    output reg  [`RSCL_GP_WIDTH-1:0]   shared_gp_enable_o,
    // Capture status
    output reg                         straps_valid_o
);

    localparam [5:0] RST_STRAPS = {`RSCL_RST_HOST_EN, `RSCL_RST_CLK_SRC,
                                   `RSCL_RST_LANE_FIX, `RSCL_RST_LITTLE,
                                   `RSCL_RST_BOOT};

    wire [5:0] strap_now;
    wire [5:0] held;
    wire       done;

    wire       lane_fix_strap_pin;
    wire       endian_strap_pin;
    wire [1:0] boot_select_strap_pins;
    wire       host_port_enable_strap;

    // Pin inputs are synchronous to clk_i; no synchroniser stage is needed
    assign lane_fix_strap_pin     = host_data_pins_i[`RSCL_HD_LANE_FIX];
    assign endian_strap_pin       = host_data_pins_i[`RSCL_HD_ENDIAN];
    assign boot_select_strap_pins = host_data_pins_i[`RSCL_HD_BOOT_HI:`RSCL_HD_BOOT_LO];
    assign host_port_enable_strap = host_data_pins_i[`RSCL_HD_HOST_EN];

    assign strap_now = {host_port_enable_strap, clock_source_strap_i,
                        lane_fix_strap_pin, endian_strap_pin, boot_select_strap_pins};

    // Single capture point; no write port exists, so nothing but reset reloads it
    rscl_capture #(
        .WIDTH   (6),
        .RST_VAL (RST_STRAPS)
    ) u_capture (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .strap_i (strap_now),
        .held_o  (held),
        .done_o  (done)
    );

    wire       held_host_en = held[5];
    wire       held_clk_src = held[4];
    wire       held_lane    = held[3];
    wire       held_little  = held[2];
    wire [1:0] held_boot    = held[1:0];

    // Capture sequencer, one-hot: wait for release, load the decode once, then lock
    localparam [2:0] ST_WAIT   = 3'h1;
    localparam [2:0] ST_DECODE = 3'h2;
    localparam [2:0] ST_LOCKED = 3'h4;

    localparam [`RSCL_GP_WIDTH-1:0] GP_SHARED = `RSCL_GP_SHARED_MASK;

    reg [2:0]                 state;
    reg [2:0]                 next_state;
    reg                       load_outputs;

    // Decoded values presented to the output registers
    reg                       next_little;
    reg                       next_lane_fix;
    reg                       next_lane;
    reg [1:0]                 next_boot_select;
    reg [3:0]                 boot_hot;
    reg                       next_boot_host;
    reg                       next_boot_rom;
    reg [1:0]                 next_rom_width;
    reg                       next_clk_square;
    reg                       next_clk_reserved;
    reg                       next_host_port;
    reg                       next_audio_port;
    wire [`RSCL_GP_WIDTH-1:0] next_gp;

    // Straps enter the capture register on the first edge out of reset and the
    // decode is loaded on the next; from then on only a state upset reloads the outputs, with the same held straps
    always @* begin
        next_state   = state;
        load_outputs = 1'b0;
        case (state)
            ST_WAIT: begin
                next_state = ST_DECODE;
            end
            ST_DECODE: begin
                // Guards against loading before the capture has happened
                if (done) begin
                    load_outputs = 1'b1;
                    next_state   = ST_LOCKED;
                end
            end
            ST_LOCKED: begin
                next_state = ST_LOCKED;
            end
            default: begin
                // An upset code restarts the pass; the held straps do not change,
                // so the reload shows nothing new
                next_state = ST_WAIT;
            end
        endcase
    end

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= ST_WAIT;
        end else begin
            state <= next_state;
        end
    end

    // Endianness: strap 0 runs big-endian, 1 little-endian
    always @* begin
        if (held_little) begin
            next_little = 1'b1;
        end else begin
            next_little = 1'b0;
        end
        next_lane_fix = held_lane;
    end

    // Narrow data lane; only the corrected big-endian case uses the top lane
    always @* begin
        case ({held_lane, held_little})
            2'h3: begin
                next_lane = `RSCL_LANE_LOW;
            end
            2'h2: begin
                next_lane = `RSCL_LANE_HIGH;
            end
            default: begin
                next_lane = `RSCL_LANE_LOW;
            end
        endcase
    end

    // One-hot view of the boot code, so each boot source is a single bit
    always @* begin
        case (held_boot)
            `RSCL_BOOT_HOST: begin
                boot_hot = 4'h1;
            end
            `RSCL_BOOT_ROM8: begin
                boot_hot = 4'h2;
            end
            `RSCL_BOOT_ROM16: begin
                boot_hot = 4'h4;
            end
            default: begin
                boot_hot = 4'h8;
            end
        endcase
    end

    // Boot source and ROM width follow from the one-hot code
    always @* begin
        next_boot_select = held_boot;
        next_boot_host   = boot_hot[0];
        next_boot_rom    = |boot_hot[3:1];
        if (boot_hot[3]) begin
            next_rom_width = `RSCL_ROMW_32;
        end else if (boot_hot[2]) begin
            next_rom_width = `RSCL_ROMW_16;
        end else if (boot_hot[1]) begin
            next_rom_width = `RSCL_ROMW_8;
        end else begin
            next_rom_width = `RSCL_ROMW_NONE;
        end
    end

    // Reserved clock code is passed on and flagged rather than blocked, so the
    // system can report a board fault; like the other straps, the pin is sampled once, on the first edge after release
    always @* begin
        if (held_clk_src) begin
            next_clk_square   = 1'b1;
            next_clk_reserved = 1'b0;
        end else begin
            next_clk_square   = 1'b0;
            next_clk_reserved = 1'b1;
        end
    end

    // Pin ownership comes from the latched strap alone; no write path reaches it,
    // so software cannot move the shared pins between peripherals
    always @* begin
        if (held_host_en) begin
            next_host_port  = 1'b1;
            next_audio_port = 1'b0;
        end else begin
            next_host_port  = 1'b0;
            next_audio_port = 1'b1;
        end
    end

    // One gate per general-purpose pin; pins outside the shared set never open,
    // whatever the strap says
    genvar g;
    generate
        for (g = 0; g < `RSCL_GP_WIDTH; g = g + 1) begin : gen_gp
            assign next_gp[g] = GP_SHARED[g] & ~held_host_en;
        end
    endgenerate

    // Output registers show the defaults while reset is low and load once (again only after a state upset)
    // after release, so late pin activity has no path to them
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            little_endian_flag_o           <= `RSCL_RST_LITTLE;
            big_endian_lane_fix_o          <= `RSCL_RST_LANE_FIX;
            narrow_data_lane_o             <= `RSCL_RST_LANE;
        end else if (load_outputs) begin
            little_endian_flag_o           <= next_little;
            big_endian_lane_fix_o          <= next_lane_fix;
            narrow_data_lane_o             <= next_lane;
        end
    end

    // Boot selection
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            boot_select_o                  <= `RSCL_RST_BOOT;
            boot_host_port_o               <= `RSCL_RST_BOOT_HOST;
            boot_rom_o                     <= `RSCL_RST_BOOT_ROM;
            boot_rom_width_o               <= `RSCL_RST_ROM_WIDTH;
        end else if (load_outputs) begin
            boot_select_o                  <= next_boot_select;
            boot_host_port_o               <= next_boot_host;
            boot_rom_o                     <= next_boot_rom;
            boot_rom_width_o               <= next_rom_width;
        end
    end

    // Clock source
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            clk_src_square_wave_o          <= `RSCL_RST_CLK_SRC;
            clk_src_reserved_o             <= `RSCL_RST_CLK_RES;
        end else if (load_outputs) begin
            clk_src_square_wave_o          <= next_clk_square;
            clk_src_reserved_o             <= next_clk_reserved;
        end
    end

    // Shared pin ownership
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            host_port_enable_o             <= `RSCL_RST_HOST_EN;
            audio_serial_port_one_enable_o <= `RSCL_RST_AUDIO;
            shared_gp_enable_o             <= `RSCL_RST_GP;
        end else if (load_outputs) begin
            host_port_enable_o             <= next_host_port;
            audio_serial_port_one_enable_o <= next_audio_port;
            shared_gp_enable_o             <= next_gp;
        end
    end

    // Valid rises with the load and stays up until the next reset
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            straps_valid_o                 <= `RSCL_RST_VALID;
        end else if (load_outputs) begin
            straps_valid_o                 <= done;
        end
    end

endmodule

// >>> verif/rscl_board_model.sv
// Board model: pull resistors plus a host driving the strap pins
`timescale 1ns/100ps
module rscl_board_model #(
    parameter [15:0] PULL = 16'h0000
) (
    input  wire        clk_i,
    input  wire        rst_b_i,
    input  wire [15:0] want_i,
    input  wire        want_clk_i,
    input  wire        wobble_i,
    output reg  [15:0] pins_o,
    output wire        clk_strap_o
);
    // Only straps and pins 15, 6, 5, 2 may be driven; the rest keep their pull
    localparam [15:0] FREE = 16'hd17c;
    assign clk_strap_o = want_clk_i;
    // Straps held through reset; wobbling afterwards must not matter
    always @(posedge clk_i or negedge rst_b_i)
        if (!rst_b_i) pins_o <= (want_i & FREE) | (PULL & ~FREE);
        else if (wobble_i) pins_o <= pins_o ^ FREE;
endmodule

// >>> verif/rscl_strap_latch_sva.sv
// Assertions on the strap latch ports
`timescale 1ns/100ps
module rscl_strap_latch_sva (
    input wire clk_i, rst_b_i, clock_source_strap_i, little_endian_flag_o,
    input wire [15:0] host_data_pins_i, shared_gp_enable_o,
    input wire big_endian_lane_fix_o, narrow_data_lane_o, boot_host_port_o,
    input wire [1:0] boot_select_o, boot_rom_width_o,
    input wire boot_rom_o, clk_src_square_wave_o, clk_src_reserved_o,
    input wire host_port_enable_o, audio_serial_port_one_enable_o, straps_valid_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence release_s;
        $rose(rst_b_i);
    endsequence
    sequence settle_s;
        !straps_valid_o ##1 !straps_valid_o ##1 straps_valid_o;
    endsequence
    valid_timing_a:
        assert property (release_s |-> settle_s) else $error("valid timing wrong");
    capture_a:
        assert property (release_s |-> ##2 {little_endian_flag_o, big_endian_lane_fix_o,
            boot_select_o, host_port_enable_o, clk_src_square_wave_o} ==
            $past({host_data_pins_i[8], host_data_pins_i[12], host_data_pins_i[4:3],
            host_data_pins_i[14], clock_source_strap_i}, 2)) else $error("bad capture");
    hold_a:
        assert property (straps_valid_o |=> $stable({little_endian_flag_o,
            big_endian_lane_fix_o, narrow_data_lane_o, boot_select_o, boot_host_port_o,
            boot_rom_o, boot_rom_width_o, clk_src_square_wave_o, clk_src_reserved_o,
            host_port_enable_o, audio_serial_port_one_enable_o, shared_gp_enable_o,
            straps_valid_o})) else $error("outputs moved");
    lane_fix_a:
        assert property (straps_valid_o && !big_endian_lane_fix_o |-> !narrow_data_lane_o)
            else $error("lane wrong");
    lane_sel_a:
        assert property (straps_valid_o |-> narrow_data_lane_o ==
            (big_endian_lane_fix_o && !little_endian_flag_o)) else $error("lane select");
    boot_dec_a:
        assert property (straps_valid_o |-> boot_host_port_o == (boot_select_o == 2'h0)
            && boot_rom_o == (boot_select_o != 2'h0) && boot_rom_width_o == boot_select_o)
            else $error("boot decode");
    clk_src_a:
        assert property (straps_valid_o |-> clk_src_reserved_o == !clk_src_square_wave_o)
            else $error("clock source");
    clk_reserved_a:
        assert property (release_s |-> ##2
            clk_src_reserved_o == !$past(clock_source_strap_i, 2))
            else $error("reserved clock flag");
    pin_owner_a:
        assert property (straps_valid_o |-> audio_serial_port_one_enable_o ==
            !host_port_enable_o && shared_gp_enable_o ==
            (host_port_enable_o ? 16'h0000 : 16'hff0b)) else $error("pin owner");
endmodule
bind rscl_strap_latch rscl_strap_latch_sva i_rscl_strap_latch_sva (.*);

// >>> verif/rscl_strap_latch_tb.sv
// Self-checking bench for the configuration strap latch
`timescale 1ns/100ps
module rscl_strap_latch_tb;
    reg         clk_i = 1'b0;
    reg         rst_b_i = 1'b0;
    reg  [31:0] rnd_s;
    reg  [31:0] rnd_c;
    reg  [15:0] want = 16'h0000;
    reg         want_clk = 1'b1;
    reg         wobble = 1'b0;
    wire [15:0] pins, gp;
    wire        cs, lf, bl, nl, bh, br, cq, cr, he, ae, sv;
    wire [1:0]  bs, bw;
    wire [29:0] got = {lf, bl, nl, bs, bh, br, bw, cq, cr, he, ae, gp, sv};
    integer     seed = 32'hf2a325dd;
    integer     n_fail = 0;
    integer     n_checks = 0;
    integer     i;
    always #20 clk_i = ~clk_i;
    rscl_board_model i_rscl_board_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .want_i(want),
        .want_clk_i(want_clk), .wobble_i(wobble), .pins_o(pins), .clk_strap_o(cs));
    rscl_strap_latch i_rscl_strap_latch (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .host_data_pins_i(pins), .clock_source_strap_i(cs), .little_endian_flag_o(lf),
        .big_endian_lane_fix_o(bl), .narrow_data_lane_o(nl), .boot_select_o(bs),
        .boot_host_port_o(bh), .boot_rom_o(br), .boot_rom_width_o(bw),
        .clk_src_square_wave_o(cq), .clk_src_reserved_o(cr), .host_port_enable_o(he),
        .audio_serial_port_one_enable_o(ae), .shared_gp_enable_o(gp), .straps_valid_o(sv));
    function [29:0] exp_out(input [15:0] p, input c, input v);
        exp_out = {p[8], p[12], p[12] & ~p[8], p[4:3], p[4:3] == 2'h0, p[4:3] != 2'h0,
            p[4:3], c, ~c, p[14], ~p[14], p[14] ? 16'h0000 : 16'hff0b, v};
    endfunction
    task chk(input [29:0] seen, input [29:0] exp_v);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp_v) begin
                n_fail = n_fail + 1;
                $display("unexpected at %0t: got %h, expected %h", $time, seen, exp_v);
            end
        end
    endtask
    task run_one(input [15:0] s, input c);
        begin
            @(posedge clk_i);
            want <= s;
            want_clk <= c;
            wobble <= 1'b0;
            rst_b_i <= 1'b0;
            repeat (5) @(posedge clk_i);
            #1 chk(got, exp_out(16'h5108, 1'b1, 1'b0));
            @(posedge clk_i);
            rst_b_i <= 1'b1;
            repeat (2) @(posedge clk_i);
            #1 chk(got, exp_out(s, c, 1'b1));
            @(posedge clk_i);
            wobble <= 1'b1;
            repeat (3) @(posedge clk_i);
            #1 chk(got, exp_out(s, c, 1'b1));
            $display("case done, straps %h clock %b", s, c);
        end
    endtask
    task test_done;
        begin
            $display("checks %0d, mismatches %0d", n_checks, n_fail);
            if (n_fail == 0 && n_checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    initial begin
        for (i = 0; i < 32; i = i + 1)
            run_one({1'b0, i[4], 1'b0, i[3], 3'h0, i[2], 3'h0, i[1:0], 3'h0}, 1'b1);
        for (i = 0; i < 40; i = i + 1) begin
            rnd_s = $random(seed);
            rnd_c = $random(seed);
            run_one(rnd_s[15:0], rnd_c[0]);
        end
        test_done;
    end
    // Each case takes 13 cycles (37440 ns for all 72); allow over twice the total
    initial begin
        #100000;
        n_fail = n_fail + 1;
        test_done;
    end
endmodule
